// ---- fse_sequencer.v ----
// data-array sector erase sequencer with interrupts, stop handling and security
// Overview of operation
// - clearing complete flag launches erase, then verify, then flag sets
// - index not 001 at launch sets access error, no erase
// - command unavailable in current mode or security sets access error
// - invalid 18-bit address or odd address sets access error
// - protected sector sets protection violation, no erase
// - verify errors set upper status bit, uncorrectable errors lower bit
// - command irq when complete flag and its enable both set
// - error irq from double or single fault flag with its enable
// - wait mode changes nothing; command irq can wake the system
// - stop request held off until a running command finishes
// - security register loaded from security byte during reset
// - new security byte only takes effect after next reset
// - four matching keys with keys enabled force security to 10
// - key words 0x0000 and 0xFFFF never match
// - array reads invalid while key verify runs
// - a wrong key locks out key verify until reset
// - key verify changes only the live security state
// - special single-chip erase-verify finding all erased unsecures
// - complete flag clear during reset sequence; parameter writes ignored
// - reset aborts any running command at once
`timescale 1ns/10ps
`include "fse_defines.vh"
module fse_sequencer #(
    parameter ERASE_CYC  = `FSE_ERASE_CYC,
    parameter VERIFY_CYC = `FSE_VERIFY_CYC
) (
    // clock and reset
    input  wire        CLK_IN,
    input  wire        RST_IN,
    // register port
    input  wire [3:0]  ADDR_IN,
    input  wire [15:0] WDATA_IN,
    input  wire        WR_IN,
    input  wire        RD_IN,
    output reg  [15:0] RDATA_OUT,
    // array back end
    input  wire [7:0]  SECBYTE_IN,
    input  wire [63:0] STORED_KEYS_IN,
    input  wire        ADDR_VALID_IN,
    input  wire        SECTOR_PROT_IN,
    input  wire        VERIFY_ERR_IN,
    input  wire        VERIFY_NCERR_IN,
    input  wire        ALL_ERASED_IN,
    input  wire        READ_SFD_IN,
    input  wire        READ_DFD_IN,
    output reg         ERASE_BUSY_OUT,
    output reg         VERIFY_BUSY_OUT,
    output reg  [17:0] ERASE_ADDR_OUT,
    output reg         READ_INVALID_OUT,
    // system modes
    input  wire        SPECIAL_MODE_IN,
    input  wire        STOP_REQ_IN,
    output reg         STOP_ACK_OUT,
    output reg         SECURED_OUT,
    // interrupt requests
    output reg         CMD_IRQ_OUT,
    output reg         ERR_IRQ_OUT
);

    localparam ST_INIT   = 3'h0;
    localparam ST_IDLE   = 3'h1;
    localparam ST_ERASE  = 3'h2;
    localparam ST_VERIFY = 3'h3;
    localparam ST_KEY    = 3'h4;

    reg [2:0]  state_r;
    reg [15:0] cnt_r;
    reg        command_complete_flag_r;
    reg        access_error_flag_r;
    reg        protection_violation_flag_r;
    reg        mg1_r;
    reg        mg0_r;
    reg        command_complete_irq_enable_r;
    reg        double_fault_irq_enable_r;
    reg        single_fault_irq_enable_r;
    reg        dfd_r;
    reg        sfd_r;
    reg [2:0]  index_r;
    reg [15:0] param0_r;
    reg [15:0] param1_r;
    reg [1:0]  sec_r;
    reg [1:0]  backdoor_key_enable_r;
    reg [63:0] keys_r;
    reg        key_lock_r;
    reg        was_special_r;

    // write select for one register word
    function wr_sel;
        input       wr;
        input [3:0] adr;
        input [3:0] target;
        begin
            wr_sel = wr && (adr == target);
        end
    endfunction

    wire wr_stat    = wr_sel(WR_IN, ADDR_IN, `FSE_A_STAT);
    wire wr_cfg     = wr_sel(WR_IN, ADDR_IN, `FSE_A_CFG);
    wire wr_errcfg  = wr_sel(WR_IN, ADDR_IN, `FSE_A_ERRCFG);
    wire wr_errstat = wr_sel(WR_IN, ADDR_IN, `FSE_A_ERRSTAT);
    wire wr_index   = wr_sel(WR_IN, ADDR_IN, `FSE_A_INDEX);
    wire wr_param   = wr_sel(WR_IN, ADDR_IN, `FSE_A_PARAM);
    wire wr_key     = wr_sel(WR_IN, ADDR_IN, `FSE_A_KEY);
    wire wr_keygo   = wr_sel(WR_IN, ADDR_IN, `FSE_A_KEYGO);
    wire launch    = wr_stat && command_complete_flag_r && WDATA_IN[`FSE_ST_COMMAND_COMPLETE_FLAG];
    wire param_ok  = command_complete_flag_r && (state_r == ST_IDLE);
    wire [17:0] gaddr = {param0_r[1:0], param1_r};
    wire secured   = (sec_r != `FSE_SEC_UNSEC);

    // launch checks: any one of them refuses the erase
    wire bad_code  = (param0_r[15:8] != `FSE_CMD_ERASE);
    wire bad_index = (index_r != `FSE_IDX_ADDR);
    wire bad_mode  = secured && !SPECIAL_MODE_IN;
    wire bad_addr  = !ADDR_VALID_IN || param1_r[0];

    // key word is acceptable and equal to the stored word
    function key_ok;
        input [15:0] pres;
        input [15:0] stor;
        begin
            key_ok = (pres != `FSE_KEY_ZERO) && (pres != `FSE_KEY_ONES)
                     && (pres == stor);
        end
    endfunction

    wire [3:0] key_hit;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_key
            assign key_hit[g] = key_ok(keys_r[16*g +: 16], STORED_KEYS_IN[16*g +: 16]);
        end
    endgenerate

    wire [15:0] stat_word = {8'h00, command_complete_flag_r, 1'b0, access_error_flag_r, protection_violation_flag_r, 2'h0, mg1_r, mg0_r};

    // fault flags: set wins over a clear in the same cycle, so no fault is lost
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            dfd_r <= 1'b0;
            sfd_r <= 1'b0;
        end else begin
            if (READ_DFD_IN) begin
                dfd_r <= 1'b1;
            end else if (wr_errstat && WDATA_IN[`FSE_ER_DFD]) begin
                dfd_r <= 1'b0;
            end
            if (READ_SFD_IN) begin
                sfd_r <= 1'b1;
            end else if (wr_errstat && WDATA_IN[`FSE_ER_SFD]) begin
                sfd_r <= 1'b0;
            end
        end
    end

    // interrupt enables
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            command_complete_irq_enable_r  <= 1'b0;
            double_fault_irq_enable_r <= 1'b0;
            single_fault_irq_enable_r <= 1'b0;
        end else begin
            if (wr_cfg) begin
                command_complete_irq_enable_r <= WDATA_IN[0];
            end
            if (wr_errcfg) begin
                double_fault_irq_enable_r <= WDATA_IN[`FSE_ER_DFD];
                single_fault_irq_enable_r <= WDATA_IN[`FSE_ER_SFD];
            end
        end
    end

    // command parameters and presented keys
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            index_r  <= 3'h0;
            param0_r <= 16'h0000;
            param1_r <= 16'h0000;
            keys_r   <= 64'h0;
        end else begin
            if (param_ok && wr_index) begin
                index_r <= WDATA_IN[2:0];
            end
            if (param_ok && wr_param) begin
                if (index_r == `FSE_IDX_CMD) begin
                    param0_r <= WDATA_IN;
                end
                if (index_r == `FSE_IDX_ADDR) begin
                    param1_r <= WDATA_IN;
                end
            end
            // only the low two index bits pick a key slot, higher slots alias
            if (param_ok && wr_key) begin
                keys_r[16*index_r[1:0] +: 16] <= WDATA_IN;
            end
        end
    end

    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_r       <= ST_INIT;
            cnt_r         <= 16'h0000;
            command_complete_flag_r        <= 1'b0;
            access_error_flag_r      <= 1'b0;
            protection_violation_flag_r      <= 1'b0;
            mg1_r         <= 1'b0;
            mg0_r         <= 1'b0;
            sec_r         <= `FSE_SEC_SECURE;
            backdoor_key_enable_r       <= 2'h0;
            ERASE_ADDR_OUT <= 18'h00000;
            key_lock_r    <= 1'b0;
            was_special_r <= 1'b0;
        end else begin
            // error flags clear only while idle, so a running command keeps its status
            if (wr_stat && command_complete_flag_r) begin
                if (WDATA_IN[`FSE_ST_ACCESS_ERROR_FLAG]) begin
                    access_error_flag_r <= 1'b0;
                end
                if (WDATA_IN[`FSE_ST_PROTECTION_VIOLATION_FLAG]) begin
                    protection_violation_flag_r <= 1'b0;
                end
            end
            case (state_r)
                ST_INIT: begin
                    sec_r         <= SECBYTE_IN[1:0];
                    backdoor_key_enable_r       <= SECBYTE_IN[7:6];
                    was_special_r <= SPECIAL_MODE_IN;
                    cnt_r         <= cnt_r + 16'h0001;
                    if (cnt_r[7:0] == `FSE_INIT_CYC) begin
                        if (SPECIAL_MODE_IN && ALL_ERASED_IN) begin
                            sec_r <= `FSE_SEC_UNSEC;
                        end
                        command_complete_flag_r <= 1'b1;
                        state_r <= ST_IDLE;
                        cnt_r <= 16'h0000;
                    end
                end
                ST_IDLE: begin
                    if (launch && !access_error_flag_r && !protection_violation_flag_r) begin
                        mg1_r <= 1'b0;
                        mg0_r <= 1'b0;
                        if (bad_code || bad_index || bad_mode || bad_addr)
                            access_error_flag_r <= 1'b1;
                        else if (SECTOR_PROT_IN)
                            protection_violation_flag_r <= 1'b1;
                        else begin
                            command_complete_flag_r         <= 1'b0;
                            ERASE_ADDR_OUT <= gaddr;
                            cnt_r          <= 16'h0000;
                            state_r        <= ST_ERASE;
                        end
                    end else if (wr_keygo && command_complete_flag_r) begin
                        if (backdoor_key_enable_r != `FSE_BACKDOOR_KEY_ENABLE_ON || key_lock_r)
                            access_error_flag_r <= 1'b1;
                        else begin
                            command_complete_flag_r  <= 1'b0;
                            state_r <= ST_KEY;
                        end
                    end
                end
                ST_ERASE: begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == ERASE_CYC[15:0] - 16'h0001) begin
                        cnt_r   <= 16'h0000;
                        state_r <= ST_VERIFY;
                    end
                end
                ST_VERIFY: begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (VERIFY_ERR_IN) begin
                        mg1_r <= 1'b1;
                    end
                    if (VERIFY_NCERR_IN) begin
                        mg0_r <= 1'b1;
                    end
                    if (cnt_r == VERIFY_CYC[15:0] - 16'h0001) begin
                        command_complete_flag_r  <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_KEY: begin
                    // the compare takes one cycle; array reads are flagged invalid for it
                    // unsecure on full match
                    if (&key_hit)
                        sec_r <= `FSE_SEC_UNSEC;
                    else begin
                        key_lock_r <= 1'b1;
                        access_error_flag_r   <= 1'b1;
                    end
                    command_complete_flag_r  <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // read data for the addressed word; the register below makes it stand one cycle
    reg [15:0] rdata_nxt;
    always @* begin
        rdata_nxt = 16'h0000;
        if (RD_IN) begin
            case (ADDR_IN)
                `FSE_A_STAT:    rdata_nxt = stat_word;
                `FSE_A_CFG:     rdata_nxt = {15'h0000, command_complete_irq_enable_r};
                `FSE_A_ERRCFG:  rdata_nxt = {14'h0000, double_fault_irq_enable_r, single_fault_irq_enable_r};
                `FSE_A_ERRSTAT: rdata_nxt = {14'h0000, dfd_r, sfd_r};
                `FSE_A_INDEX:   rdata_nxt = {13'h0000, index_r};
                `FSE_A_PARAM:   rdata_nxt = (index_r == `FSE_IDX_CMD) ? param0_r
                                                                      : param1_r;
                `FSE_A_SEC:     rdata_nxt = {8'h00, backdoor_key_enable_r, 4'h0, sec_r};
                `FSE_A_MODE:    rdata_nxt = {14'h0000, key_lock_r, was_special_r};
                default:        rdata_nxt = 16'h0000;
            endcase
        end
    end

    // registered outputs
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT        <= 16'h0000;
            ERASE_BUSY_OUT   <= 1'b0;
            VERIFY_BUSY_OUT  <= 1'b0;
            READ_INVALID_OUT <= 1'b0;
            STOP_ACK_OUT     <= 1'b0;
            SECURED_OUT      <= 1'b1;
            CMD_IRQ_OUT      <= 1'b0;
            ERR_IRQ_OUT      <= 1'b0;
        end else begin
            RDATA_OUT       <= rdata_nxt;
            ERASE_BUSY_OUT  <= (state_r == ST_ERASE);
            VERIFY_BUSY_OUT <= (state_r == ST_VERIFY);
            READ_INVALID_OUT <= (state_r == ST_KEY);
            // nothing here depends on wait mode
            STOP_ACK_OUT <= STOP_REQ_IN && command_complete_flag_r;
            SECURED_OUT  <= secured;
            CMD_IRQ_OUT <= command_complete_flag_r && command_complete_irq_enable_r;
            ERR_IRQ_OUT <= (dfd_r && double_fault_irq_enable_r) || (sfd_r && single_fault_irq_enable_r);
        end
    end

endmodule

// ---- fse_defines.vh ----
// constants for the flash sector erase, interrupt and security sequencer
`ifndef FSE_DEFINES_VH
`define FSE_DEFINES_VH
// register word addresses
`define FSE_A_STAT      4'h0
`define FSE_A_CFG       4'h1
`define FSE_A_ERRCFG    4'h2
`define FSE_A_ERRSTAT   4'h3
`define FSE_A_INDEX     4'h4
`define FSE_A_PARAM     4'h5
`define FSE_A_SEC       4'h6
`define FSE_A_KEY       4'h7
`define FSE_A_KEYGO     4'h8
`define FSE_A_MODE      4'h9
// status register bits
`define FSE_ST_COMMAND_COMPLETE_FLAG     7
`define FSE_ST_ACCESS_ERROR_FLAG   5
`define FSE_ST_PROTECTION_VIOLATION_FLAG   4
`define FSE_ST_MG1      1
`define FSE_ST_MG0      0
// error register bits
`define FSE_ER_DFD      1
`define FSE_ER_SFD      0
// command codes and slot indices
`define FSE_CMD_ERASE   8'h12
`define FSE_IDX_CMD     3'h0
`define FSE_IDX_ADDR    3'h1
// security values
`define FSE_SEC_UNSEC   2'h2
`define FSE_SEC_SECURE  2'h3
`define FSE_BACKDOOR_KEY_ENABLE_ON    2'h2
`define FSE_KEY_ZERO    16'h0000
`define FSE_KEY_ONES    16'hFFFF
// configuration field address of the security byte
`define FSE_SECBYTE_ADR 18'h3FF0F
// timing
`define FSE_ERASE_CYC   16'h0040
`define FSE_VERIFY_CYC  16'h0010
`define FSE_INIT_CYC    8'h08
`endif

// ---- fse_checker.sv ----
// port-level assertions for the sector erase sequencer
`timescale 1ns/10ps
module fse_checker #(
    parameter ERASE_CYC  = 64,
    parameter VERIFY_CYC = 16
) (
    // clock and reset
    input wire        CLK_IN,
    input wire        RST_IN,
    // watched ports
    input wire        WR_IN,
    input wire        READ_SFD_IN,
    input wire        READ_DFD_IN,
    input wire        ERASE_BUSY_OUT,
    input wire        VERIFY_BUSY_OUT,
    input wire [17:0] ERASE_ADDR_OUT,
    input wire        READ_INVALID_OUT,
    input wire        STOP_ACK_OUT,
    input wire        SECURED_OUT,
    input wire        CMD_IRQ_OUT,
    input wire        ERR_IRQ_OUT
);
    reg  [15:0] er_r;
    reg  [15:0] vf_r;
    reg  [3:0]  init_r;
    wire        cause = WR_IN | READ_SFD_IN | READ_DFD_IN;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // counters restart on reset, so an aborted erase never leaves a stale length behind
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            er_r   <= 16'h0000;
            vf_r   <= 16'h0000;
            init_r <= 4'h0;
        end else begin
            er_r   <= ERASE_BUSY_OUT ? er_r + 16'h0001 : 16'h0000;
            vf_r   <= VERIFY_BUSY_OUT ? vf_r + 16'h0001 : 16'h0000;
            init_r <= (init_r == 4'hF) ? init_r : init_r + 4'h1;
        end
    end
    sequence s_erase_end;
        $fell(ERASE_BUSY_OUT);
    endsequence
    sequence s_verify_end;
        $fell(VERIFY_BUSY_OUT);
    endsequence
    a_erase_length: assert property (s_erase_end |-> er_r == ERASE_CYC)
        else $error("erase phase has wrong length");
    a_verify_follows: assert property (s_erase_end |-> VERIFY_BUSY_OUT)
        else $error("verify did not follow erase");
    a_verify_length: assert property (s_verify_end |-> vf_r == VERIFY_CYC)
        else $error("verify phase has wrong length");
    a_addr_held: assert property (ERASE_BUSY_OUT && $past(ERASE_BUSY_OUT) |-> $stable(ERASE_ADDR_OUT))
        else $error("erase address moved during erase");
    a_irq_quiet_busy: assert property (ERASE_BUSY_OUT || VERIFY_BUSY_OUT |-> !CMD_IRQ_OUT)
        else $error("command irq high while busy");
    a_stop_held_off: assert property (STOP_ACK_OUT |-> !ERASE_BUSY_OUT && !VERIFY_BUSY_OUT)
        else $error("stop granted during a command");
    a_init_quiet: assert property (init_r < 4'h8 |-> !CMD_IRQ_OUT && !ERASE_BUSY_OUT)
        else $error("activity during reset sequence");
    a_secure_no_rise: assert property (!$rose(SECURED_OUT))
        else $error("security state re-armed without reset");
    a_inval_key_only: assert property (READ_INVALID_OUT |-> !ERASE_BUSY_OUT)
        else $error("read invalid during erase");
    a_err_irq_cause: assert property ($rose(ERR_IRQ_OUT) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
        else $error("error irq rose without a cause");
endmodule
bind fse_sequencer fse_checker #(.ERASE_CYC(ERASE_CYC), .VERIFY_CYC(VERIFY_CYC)) i_chk (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .WR_IN(WR_IN), .READ_SFD_IN(READ_SFD_IN),
    .READ_DFD_IN(READ_DFD_IN), .ERASE_BUSY_OUT(ERASE_BUSY_OUT), .VERIFY_BUSY_OUT(VERIFY_BUSY_OUT),
    .ERASE_ADDR_OUT(ERASE_ADDR_OUT), .READ_INVALID_OUT(READ_INVALID_OUT),
    .STOP_ACK_OUT(STOP_ACK_OUT), .SECURED_OUT(SECURED_OUT), .CMD_IRQ_OUT(CMD_IRQ_OUT),
    .ERR_IRQ_OUT(ERR_IRQ_OUT));

// ---- fse_array_model.sv ----
// behavioural array back end answering the sequencer
`timescale 1ns/10ps
module fse_array_model (
    // sequencer side and test knobs: bad address, protected, verify error, uncorrectable
    input  wire       erase_busy_in,
    input  wire       verify_busy_in,
    input  wire [3:0] knob_in,
    // answers
    output wire       addr_valid_out,
    output wire       sector_prot_out,
    output wire       verify_err_out,
    output wire       verify_ncerr_out
);
    wire active = erase_busy_in | verify_busy_in;
    assign addr_valid_out  = !knob_in[3];
    assign sector_prot_out = knob_in[2];
    // outside an operation the verify lines show the opposite, so late sampling shows up
    assign verify_err_out   = active ? knob_in[1] : !knob_in[1];
    assign verify_ncerr_out = active ? knob_in[0] : !knob_in[0];
endmodule

// ---- test_fse_sequencer.sv ----
// self-checking bench for the sector erase sequencer
`timescale 1ns/10ps
`include "fse_defines.vh"
module test_fse_sequencer;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [3:0]  addr = 4'h0;
    reg  [15:0] wdata = 16'h0000;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg  [7:0]  secbyte = 8'h80;
    reg  [63:0] keys = 64'h4444_3333_2222_0000;
    reg  [3:0]  knob = 4'h0;
    reg         sfd = 1'b0;
    reg         dfd = 1'b0;
    reg         special = 1'b0;
    reg         stop = 1'b0;
    reg         erased = 1'b0;
    reg         seen_er = 1'b0;
    reg         seen_inv = 1'b0;
    reg  [17:0] last_ad = 18'h00000;
    integer     num_errors = 0;
    integer     num_checks = 0;
    integer     cycles = 0;
    wire [15:0] rdata;
    wire [17:0] eaddr;
    wire        av, sp, ve, vn, ebusy, vbusy, rinv, sack, secured, cirq, eirq;
    fse_sequencer #(.ERASE_CYC(16'h0008), .VERIFY_CYC(16'h0004)) i_dut (
        .CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .SECBYTE_IN(secbyte), .STORED_KEYS_IN(keys),
        .ADDR_VALID_IN(av), .SECTOR_PROT_IN(sp), .VERIFY_ERR_IN(ve), .VERIFY_NCERR_IN(vn),
        .ALL_ERASED_IN(erased), .READ_SFD_IN(sfd), .READ_DFD_IN(dfd), .ERASE_BUSY_OUT(ebusy),
        .VERIFY_BUSY_OUT(vbusy), .ERASE_ADDR_OUT(eaddr), .READ_INVALID_OUT(rinv),
        .SPECIAL_MODE_IN(special), .STOP_REQ_IN(stop), .STOP_ACK_OUT(sack),
        .SECURED_OUT(secured), .CMD_IRQ_OUT(cirq), .ERR_IRQ_OUT(eirq));
    fse_array_model i_mem (.erase_busy_in(ebusy), .verify_busy_in(vbusy), .knob_in(knob),
        .addr_valid_out(av), .sector_prot_out(sp), .verify_err_out(ve), .verify_ncerr_out(vn));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (ebusy) begin
            seen_er <= 1'b1;
            last_ad <= eaddr;
        end
        if (rinv) begin
            seen_inv <= 1'b1;
        end
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            $display("ERROR at %0t: run did not finish", $time);
            finish_test;
        end
    end
    task finish_test;
        begin
            if (num_errors == 0 && num_checks > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    task chkw(input [17:0] got, input [17:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR at %0t: word %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chk1(input got, input exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR at %0t: flag %b expected %b", $time, got, exp);
            end
        end
    endtask
    task bus_wr(input [3:0] a, input [15:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task bus_rd(input [3:0] a, output [15:0] d);
        begin
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(negedge clk);
            d = rdata;
            @(posedge clk);
        end
    endtask
    task rd_chk(input [3:0] a, input [15:0] e);
        reg [15:0] v;
        begin
            bus_rd(a, v);
            chkw({2'h0, v}, {2'h0, e});
        end
    endtask
    task wait_done;
        reg [15:0] v;
        integer n;
        begin
            v = 16'h0000;
            for (n = 0; n < 100 && v[7] !== 1'b1; n = n + 1) bus_rd(`FSE_A_STAT, v);
        end
    endtask
    task do_reset;
        begin
            rst <= 1'b1;
            repeat (10) @(posedge clk);
            rst <= 1'b0;
            @(posedge clk);
            rd_chk(`FSE_A_STAT, 16'h0000);
            wait_done;
        end
    endtask
    task launch(input [17:0] ad, input [2:0] ix);
        begin
            bus_wr(`FSE_A_INDEX, 16'h0000);
            bus_wr(`FSE_A_PARAM, {`FSE_CMD_ERASE, 6'h00, ad[17:16]});
            bus_wr(`FSE_A_INDEX, 16'h0001);
            bus_wr(`FSE_A_PARAM, ad[15:0]);
            bus_wr(`FSE_A_INDEX, {13'h0000, ix});
            bus_wr(`FSE_A_STAT, 16'h0080);
        end
    endtask
    task run_case(input [2:0] ix, input [17:0] ad, input [3:0] k, input [15:0] st, input er);
        begin
            knob <= k;
            seen_er = 1'b0;
            launch(ad, ix);
            wait_done;
            rd_chk(`FSE_A_STAT, st);
            chk1(seen_er, er);
            if (er) chkw(last_ad, ad);
            bus_wr(`FSE_A_STAT, 16'h0030);
        end
    endtask
    task present(input [63:0] k);
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                bus_wr(`FSE_A_INDEX, i[15:0]);
                bus_wr(`FSE_A_KEY, k[16*i +: 16]);
            end
            bus_wr(`FSE_A_KEYGO, 16'h0001);
            wait_done;
            bus_wr(`FSE_A_STAT, 16'h0030);
        end
    endtask
    task pulse(input dbl);
        begin
            sfd <= !dbl;
            dfd <= dbl;
            @(posedge clk);
            sfd <= 1'b0;
            dfd <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    initial begin
        do_reset;
        rd_chk(`FSE_A_SEC, 16'h0080);
        run_case(3'h1, 18'h10020, 4'h0, 16'h00A0, 1'b0);
        present(keys);
        chk1(secured, 1'b1);
        rd_chk(`FSE_A_MODE, 16'h0002);
        keys <= 64'h4444_3333_2222_1111;
        present(64'h4444_3333_2222_1111);
        chk1(secured, 1'b1);
        secbyte <= 8'h02;
        rd_chk(`FSE_A_SEC, 16'h0080);
        secbyte <= 8'h80;
        do_reset;
        seen_inv = 1'b0;
        present(keys);
        chk1(seen_inv, 1'b1);
        chk1(secured, 1'b0);
        rd_chk(`FSE_A_SEC, 16'h0082);
        bus_wr(`FSE_A_CFG, 16'h0001);
        run_case(3'h2, 18'h10020, 4'h0, 16'h00A0, 1'b0);
        run_case(3'h1, 18'h10021, 4'h0, 16'h00A0, 1'b0);
        run_case(3'h1, 18'h10020, 4'h8, 16'h00A0, 1'b0);
        run_case(3'h1, 18'h10020, 4'h4, 16'h0090, 1'b0);
        stop <= 1'b1;
        run_case(3'h1, 18'h10020, 4'h0, 16'h0080, 1'b1);
        chk1(sack, 1'b1);
        chk1(cirq, 1'b1);
        run_case(3'h1, 18'h2FFFE, 4'h3, 16'h0083, 1'b1);
        bus_wr(`FSE_A_CFG, 16'h0000);
        repeat (2) @(posedge clk);
        chk1(cirq, 1'b0);
        bus_wr(`FSE_A_ERRCFG, 16'h0002);
        pulse(1'b0);
        chk1(eirq, 1'b0);
        pulse(1'b1);
        chk1(eirq, 1'b1);
        bus_wr(`FSE_A_ERRSTAT, 16'h0003);
        repeat (2) @(posedge clk);
        chk1(eirq, 1'b0);
        special <= 1'b1;
        erased <= 1'b1;
        launch(18'h10020, 3'h1);
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        chk1(ebusy, 1'b0);
        do_reset;
        chk1(secured, 1'b0);
        rd_chk(`FSE_A_MODE, 16'h0001);
        finish_test;
    end
endmodule
